// >>> bench/mftc_event_source.sv
/*
 * Model of the outside source that drives the shared event pin.
 * Assumes the bench calls edge_to from its main sequence, one call at a time.
 */
module mftc_event_source
(
	// Clock
	input wire logic clock,
	// Shared pin
	output logic pin
);
	timeunit 1ns;
	timeprecision 100ps;

	initial pin = 1'b1;

	// Pin moves off the clock edge, since a real source is asynchronous
	task automatic edge_to(input logic level);
		@(posedge clock);
		#3 pin = level;
		// Each level is held long enough for both-edge detection
		repeat (4) @(posedge clock);
	endtask
endmodule // mftc_event_source

// >>> bench/multifunction_timer_capture_test.sv
/*
 * Self-checking bench for the multifunction timer.
 * Assumes a CPU instruction of two clocks, so instr_step toggles.
 */
`define CHK(got, exp) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) \
		begin \
			err_total++; \
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end

module multifunction_timer_capture_test
	import mftc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	typedef struct {logic [7:0] load; logic [7:0] exp_count;} mftc_row_t;
	localparam int CYCLE_LIMIT = 6000;
	localparam logic [7:0] EDGE_COUNTS [4] = '{8'h00, 8'h01, 8'h01, 8'h02};
	mftc_row_t rows [4] = '{'{8'h00, 8'h00}, '{8'h5A, 8'h5A},
		'{8'hFF, 8'hFF}, '{8'h3C, 8'h3C}};
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic stop_mode = 1'b0;
	logic instr_step = 1'b1;
	logic [5:0] cpu_addr = 6'h00;
	logic cpu_wr = 1'b0;
	logic cpu_rd = 1'b0;
	logic [3:0] cpu_wdata = 4'h0;
	logic [3:0] cpu_rdata;
	logic bit_wr = 1'b0;
	logic [5:0] bit_addr = 6'h00;
	logic [1:0] bit_pos = 2'h0;
	logic bit_value = 1'b0;
	logic timer_irq_clear = 1'b0;
	logic timer_irq_mask = 1'b0;
	logic timer_irq_request;
	logic timer_irq_out;
	logic event_input_pin;
	logic port_pin_in;
	logic external_irq_zero;
	logic capture_done_flag;
	logic capture_overrun_flag;
	int err_total = 0;
	int n_tests = 0;
	int cycles = 0;

	mftc_timer dut (.clock(clock), .reset(reset), .stop_mode(stop_mode),
		.instr_step(instr_step), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
		.cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.bit_wr(bit_wr), .bit_addr(bit_addr), .bit_pos(bit_pos),
		.bit_value(bit_value), .timer_irq_clear(timer_irq_clear),
		.timer_irq_mask(timer_irq_mask),
		.timer_irq_request(timer_irq_request),
		.timer_irq_out(timer_irq_out), .event_input_pin(event_input_pin),
		.port_pin_in(port_pin_in), .external_irq_zero(external_irq_zero),
		.capture_done_flag(capture_done_flag),
		.capture_overrun_flag(capture_overrun_flag));

	mftc_event_source src (.clock(clock), .pin(event_input_pin));

	always #5 clock = ~clock;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One strobe of either kind per call, taken at the second edge
	task automatic xfer(input logic w, input logic [5:0] a,
		input logic [3:0] d, output logic [3:0] q);
		@(posedge clock);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_wr <= w;
		cpu_rd <= !w;
		@(posedge clock);
		cpu_wr <= 1'b0;
		cpu_rd <= 1'b0;
		#1 q = cpu_rdata;
	endtask

	task automatic wr(input logic [5:0] a, input logic [3:0] d);
		logic [3:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [5:0] a, output logic [3:0] d);
		xfer(1'b0, a, 4'h0, d);
	endtask

	task automatic mode(input logic [3:0] m);
		wr(ADDR_TIMER_MODE_FIRST, m);
		// Two instructions of two clocks each before the mode is valid
		repeat (4) @(posedge clock);
	endtask

	task automatic reload(input logic [7:0] v);
		wr(ADDR_RELOAD_FIRST, v[3:0]);
		wr(ADDR_RELOAD_SECOND, v[7:4]);
	endtask

	task automatic count(output logic [7:0] v);
		rd(ADDR_READ_DIRECT, v[7:4]);
		rd(ADDR_READ_LATCHED, v[3:0]);
	endtask

	task automatic bit_write(input logic [5:0] a, input logic [1:0] p,
		input logic v);
		@(posedge clock);
		bit_addr <= a;
		bit_pos <= p;
		bit_value <= v;
		bit_wr <= 1'b1;
		@(posedge clock);
		bit_wr <= 1'b0;
	endtask

	task automatic clear_req;
		@(posedge clock);
		timer_irq_clear <= 1'b1;
		@(posedge clock);
		timer_irq_clear <= 1'b0;
		#1;
	endtask

	task automatic wait_req;
		for (int i = 0; i < 60 && timer_irq_request !== 1'b1; i++)
			@(posedge clock);
		#1;
	endtask

	// Hang guard
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		instr_step <= !instr_step;
		if (cycles == CYCLE_LIMIT)
		begin
			err_total++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [7:0] v;
		logic [7:0] w;
		logic [3:0] f;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		count(v);
		`CHK(v, COUNT_RESET);
		`CHK(timer_irq_request, 1'b0);
		rd(ADDR_CAPTURE_FLAGS, f);
		`CHK(f, 4'h0);
		// Slowest tap keeps the count still while rows are checked
		foreach (rows[i])
		begin
			reload(rows[i].load);
			count(v);
			`CHK(v, rows[i].exp_count);
		end
		mode(4'h6);
		reload(8'hFE);
		wait_req();
		`CHK(timer_irq_request, 1'b1);
		count(v);
		`CHK(v[7:4], 4'h0);
		`CHK(timer_irq_out, 1'b1);
		for (int m = 1; m >= 0; m--)
		begin
			@(posedge clock);
			timer_irq_mask <= m[0];
			repeat (2) @(posedge clock);
			#1 `CHK(timer_irq_out, !m[0]);
		end
		mode(4'hE);
		reload(8'hF0);
		clear_req();
		`CHK(timer_irq_request, 1'b0);
		wait_req();
		count(v);
		`CHK(v[7:4], 4'hF);
		mode(4'h0);
		repeat (50) @(posedge clock);
		#1 `CHK(timer_irq_request, 1'b1);
		// Shared pin routing, then event counting for every edge code
		src.edge_to(1'b0);
		#1 `CHK(port_pin_in, 1'b0);
		`CHK(external_irq_zero, 1'b1);
		src.edge_to(1'b1);
		wr(ADDR_PIN_FUNCTION_B, 4'h4);
		mode(4'h7);
		for (int e = 0; e < 4; e++)
		begin
			wr(ADDR_TIMER_MODE_SECOND, e[3:0]);
			reload(8'h00);
			src.edge_to(1'b0);
			#1 `CHK(port_pin_in, 1'b1);
			`CHK(external_irq_zero, 1'b0);
			src.edge_to(1'b1);
			count(v);
			`CHK(v, EDGE_COUNTS[e]);
		end
		mode(4'hF);
		reload(8'hFF);
		clear_req();
		src.edge_to(1'b0);
		src.edge_to(1'b1);
		`CHK(timer_irq_request, 1'b1);
		count(v);
		`CHK(v, 8'hFF);
		// Capture: counter parked high first, so a missed clear shows
		mode(4'h0);
		reload(8'hC3);
		wr(ADDR_TIMER_MODE_SECOND, 4'h5);
		mode(4'h6);
		clear_req();
		repeat (10) @(posedge clock);
		src.edge_to(1'b0);
		#1 `CHK(capture_done_flag, 1'b1);
		`CHK(timer_irq_request, 1'b1);
		rd(ADDR_READ_LATCHED, v[3:0]);
		rd(ADDR_READ_DIRECT, v[7:4]);
		count(w);
		`CHK(w, v);
		`CHK(v[7:4], 4'h0);
		`CHK(v == 8'h00, 1'b0);
		src.edge_to(1'b1);
		src.edge_to(1'b0);
		#1 `CHK(capture_overrun_flag, 1'b1);
		rd(ADDR_CAPTURE_FLAGS, f);
		`CHK(f, 4'h3);
		bit_write(ADDR_CAPTURE_FLAGS, FLAG_DONE_POS, 1'b0);
		rd(ADDR_CAPTURE_FLAGS, f);
		`CHK(f, 4'h2);
		bit_write(ADDR_CAPTURE_FLAGS, FLAG_DONE_POS, 1'b1);
		// A clear aimed at another address must leave the flags alone
		bit_write(ADDR_PIN_FUNCTION_B, FLAG_OVERRUN_POS, 1'b0);
		rd(ADDR_CAPTURE_FLAGS, f);
		`CHK(f, 4'h2);
		@(posedge clock);
		stop_mode <= 1'b1;
		@(posedge clock);
		stop_mode <= 1'b0;
		rd(ADDR_CAPTURE_FLAGS, f);
		`CHK(f, 4'h0);
		test_done();
	end
endmodule // multifunction_timer_capture_test

// >>> hdl/mftc_edge_detect.sv
/*
 * Two-flip-flop synchroniser and edge detector for the event pin.
 * Assumes the pin is asynchronous to clock and edges are far enough apart.
 */
module mftc_edge_detect
	import mftc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Raw pin and edge type
	input wire logic pin_raw,
	input wire logic [1:0] edge_select,
	// Synchronised level and selected edge
	output logic pin_sync,
	output logic edge_pulse
);

	logic meta_reg;
	logic sync_reg;
	logic prev_reg;
	logic rise;
	logic fall;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			prev_reg <= 1'b1;
		end
		else
		begin
			meta_reg <= pin_raw;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign rise = sync_reg && !prev_reg;
	assign fall = !sync_reg && prev_reg;
	assign pin_sync = sync_reg;

	always_comb
	begin
		case (edge_select)
			EDGE_FALL: edge_pulse = fall;
			EDGE_RISE: edge_pulse = rise;
			EDGE_BOTH: edge_pulse = fall || rise;
			default: edge_pulse = 1'b0;
		endcase
	end

endmodule // mftc_edge_detect

// >>> hdl/mftc_pkg.sv
/*
 * Constants shared by the multifunction timer: register addresses on the
 * 4-bit CPU register port, field positions, reset values and codes.
 * Assumes a 6-bit register address space and 4-bit data.
 */
package mftc_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_TIMER_MODE_FIRST = 6'h09;
	localparam logic [5:0] ADDR_RELOAD_FIRST = 6'h0A;
	localparam logic [5:0] ADDR_RELOAD_SECOND = 6'h0B;
	localparam logic [5:0] ADDR_READ_LATCHED = 6'h0A;
	localparam logic [5:0] ADDR_READ_DIRECT = 6'h0B;
	localparam logic [5:0] ADDR_CAPTURE_FLAGS = 6'h21;
	localparam logic [5:0] ADDR_PIN_FUNCTION_B = 6'h24;
	localparam logic [5:0] ADDR_TIMER_MODE_SECOND = 6'h26;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int RELOAD_MODE_POS = 3;
	localparam int CAPTURE_ENABLE_POS = 2;
	localparam int ROUTE_BIT_POS = 2;
	localparam logic [1:0] FLAG_DONE_POS = 2'h0;
	localparam logic [1:0] FLAG_OVERRUN_POS = 2'h1;

	// ----------------------------------------------------------------
	// Codes and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] CLK_SEL_EVENT = 3'h7;
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_RISE = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [3:0] MODE_FIRST_RESET = 4'h0;
	localparam logic [2:0] MODE_SECOND_RESET = 3'h0;
	localparam logic [3:0] PIN_FUNCTION_RESET = 4'h0;
	localparam logic [3:0] NIBBLE_RESET = 4'h0;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COUNT_TOP = 8'hFF;
	localparam logic [1:0] MODE_FIRST_DELAY = 2'h2;
	localparam int PRESCALER_WIDTH = 11;

endpackage

// >>> hdl/mftc_prescaler.sv
/*
 * Free-running system prescaler with selectable taps of 2048, 512, 128,
 * 32, 8, 4 and 2 instruction cycles; one instruction cycle per clock.
 * The event code selects no tap. Outputs a one-cycle enable pulse.
 */
module mftc_prescaler
	import mftc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	input wire logic stop_mode,
	// Tap selection
	input wire logic [2:0] clock_select,
	output logic tap_pulse
);

	logic [PRESCALER_WIDTH-1:0] div_reg;
	logic [PRESCALER_WIDTH-1:0] tap_mask;

	always_ff @(posedge clock)
	begin
		if (reset || stop_mode)
			div_reg <= '0;
		else
			div_reg <= div_reg + 1'b1;
	end

	always_comb
	begin
		case (clock_select)
			3'h0: tap_mask = 11'h7FF;
			3'h1: tap_mask = 11'h1FF;
			3'h2: tap_mask = 11'h07F;
			3'h3: tap_mask = 11'h01F;
			3'h4: tap_mask = 11'h007;
			3'h5: tap_mask = 11'h003;
			3'h6: tap_mask = 11'h001;
			default: tap_mask = 11'h000;
		endcase
	end

	// A tap fires when all bits below its divisor are ones
	assign tap_pulse = (clock_select != CLK_SEL_EVENT) &&
		((div_reg & tap_mask) == tap_mask);

endmodule // mftc_prescaler

// >>> hdl/mftc_timer.sv
/*
 * 8-bit multifunction timer: free-running, reload, event counting and
 * input capture, with a 4-bit CPU register port and bit access for flags.
 * Assumes one instruction cycle per clock, and that the CPU marks the end
 * of each instruction with instr_step.
 */
// Notes on behaviour
// - Route bit sends pin to port or timer.
// - Code 111 counts selected event pin edges.
// - Event counting otherwise free-running or reload.
// - Capture edge sets capture done flag.
// - Done flag bit access, clear only, reset.
// - Edge or overflow while done sets overrun.
// - Overrun flag bit access, clear only, reset.
// - Capture off, reload off: free-running counter.
// - Reset clears counter and mode bits.
// - Count past FF overflows, sets request flag.
// - Free-running overflow returns count to zero.
// - Reload mode overflow with capture off loads reload pair.
// - Completed reload write loads counter at once.
// - Enabling capture clears the counter.
// - Capture copies count, sets flags, clears.
// - Request flag cleared only by software, stop mode or reset.
// - Second reload nibble write loads counter.
// - Direct nibble read latches other nibble.
// - First mode write valid two instructions later.
// - Edge codes: none, fall, rise, both.
module mftc_timer
	import mftc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	input wire logic stop_mode,
	input wire logic instr_step,
	// CPU nibble register port
	input wire logic [5:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [3:0] cpu_wdata,
	output logic [3:0] cpu_rdata,
	// CPU bit access to the capture flags
	input wire logic bit_wr,
	input wire logic [5:0] bit_addr,
	input wire logic [1:0] bit_pos,
	input wire logic bit_value,
	// Interrupt control bits
	input wire logic timer_irq_clear,
	input wire logic timer_irq_mask,
	output logic timer_irq_request,
	output logic timer_irq_out,
	// Shared pin
	input wire logic event_input_pin,
	output logic port_pin_in,
	output logic external_irq_zero,
	// Status
	output logic capture_done_flag,
	output logic capture_overrun_flag
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [3:0] timer_mode_first_reg;
	logic [3:0] mode_pending_reg;
	logic [1:0] mode_delay_reg;
	logic [2:0] timer_mode_second_reg;
	logic [3:0] pin_function_select_b_reg;
	logic [3:0] reload_nibble_first_reg;
	logic [3:0] reload_nibble_second_reg;
	logic [7:0] count_value_reg;
	logic [7:0] capture_reg;
	logic [3:0] readback_nibble_latched_reg;
	logic [3:0] cpu_rdata_reg;
	logic timer_irq_request_reg;
	logic irq_out_reg;
	logic capture_done_flag_reg;
	logic capture_overrun_flag_reg;
	logic port_pin_reg;
	logic ext_irq_reg;

	// ----------------------------------------------------------------
	// Decodes
	// ----------------------------------------------------------------
	logic [2:0] clock_select;
	logic reload_mode_bit;
	logic capture_enable_bit;
	logic [1:0] edge_select;
	logic route_bit;
	logic tap_pulse;
	logic pin_sync;
	logic pin_edge;
	logic event_edge;
	logic tick;
	logic reload_wr;
	logic mode2_wr;
	logic capture_start;
	logic capture_hit;
	logic overflow;
	logic clear_done;
	logic clear_overrun;
	logic [3:0] rdata_next;

	assign clock_select = timer_mode_first_reg[2:0];
	assign reload_mode_bit = timer_mode_first_reg[RELOAD_MODE_POS];
	assign capture_enable_bit = timer_mode_second_reg[CAPTURE_ENABLE_POS];
	assign edge_select = timer_mode_second_reg[1:0];
	assign route_bit = pin_function_select_b_reg[ROUTE_BIT_POS];

	assign reload_wr = cpu_wr && (cpu_addr == ADDR_RELOAD_SECOND);
	assign mode2_wr = cpu_wr && (cpu_addr == ADDR_TIMER_MODE_SECOND);
	assign capture_start = mode2_wr && cpu_wdata[CAPTURE_ENABLE_POS] &&
		!capture_enable_bit;

	// Edges only reach the timer while the pin is routed to it
	assign event_edge = pin_edge && route_bit;

	// Capture uses the internal tap, edges never advance the count there
	assign tick = (!capture_enable_bit && clock_select == CLK_SEL_EVENT) ?
		event_edge : tap_pulse;
	assign capture_hit = capture_enable_bit && event_edge;
	assign overflow = tick && (count_value_reg == COUNT_TOP) &&
		!reload_wr && !capture_start && !capture_hit;

	assign clear_done = bit_wr && bit_addr == ADDR_CAPTURE_FLAGS &&
		bit_pos == FLAG_DONE_POS && !bit_value;
	assign clear_overrun = bit_wr && bit_addr == ADDR_CAPTURE_FLAGS &&
		bit_pos == FLAG_OVERRUN_POS && !bit_value;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	mftc_prescaler u_prescaler (
		.clock(clock),
		.reset(reset),
		.stop_mode(stop_mode),
		.clock_select(clock_select),
		.tap_pulse(tap_pulse)
	);

	mftc_edge_detect u_edge (
		.clock(clock),
		.reset(reset),
		.pin_raw(event_input_pin),
		.edge_select(edge_select),
		.pin_sync(pin_sync),
		.edge_pulse(pin_edge)
	);

	// ----------------------------------------------------------------
	// Mode registers
	// ----------------------------------------------------------------
	// The first mode register is staged so the new mode lands two
	// instructions after the write, as the CPU pipeline expects.
	always_ff @(posedge clock)
	begin
		if (reset || stop_mode)
		begin
			timer_mode_first_reg <= MODE_FIRST_RESET;
			mode_pending_reg <= MODE_FIRST_RESET;
			mode_delay_reg <= 2'h0;
		end
		else if (cpu_wr && cpu_addr == ADDR_TIMER_MODE_FIRST)
		begin
			mode_pending_reg <= cpu_wdata;
			mode_delay_reg <= MODE_FIRST_DELAY;
		end
		else if (instr_step && mode_delay_reg != 2'h0)
		begin
			mode_delay_reg <= mode_delay_reg - 2'h1;
			if (mode_delay_reg == 2'h1)
				timer_mode_first_reg <= mode_pending_reg;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset || stop_mode)
			timer_mode_second_reg <= MODE_SECOND_RESET;
		else if (mode2_wr)
			timer_mode_second_reg <= cpu_wdata[2:0];
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			pin_function_select_b_reg <= PIN_FUNCTION_RESET;
		else if (cpu_wr && cpu_addr == ADDR_PIN_FUNCTION_B)
			pin_function_select_b_reg <= cpu_wdata;
	end

	// ----------------------------------------------------------------
	// Reload pair
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (reset || stop_mode)
		begin
			reload_nibble_first_reg <= NIBBLE_RESET;
			reload_nibble_second_reg <= NIBBLE_RESET;
		end
		else if (cpu_wr && cpu_addr == ADDR_RELOAD_FIRST)
			reload_nibble_first_reg <= cpu_wdata;
		else if (reload_wr)
			reload_nibble_second_reg <= cpu_wdata;
	end

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (reset || stop_mode)
			count_value_reg <= COUNT_RESET;
		else if (reload_wr)
			count_value_reg <= {cpu_wdata,
				reload_nibble_first_reg};
		else if (capture_start)
			count_value_reg <= COUNT_RESET;
		else if (capture_hit)
			count_value_reg <= COUNT_RESET;
		else if (overflow && reload_mode_bit && !capture_enable_bit)
			count_value_reg <= {reload_nibble_second_reg,
				reload_nibble_first_reg};
		else if (overflow)
			count_value_reg <= COUNT_RESET;
		else if (tick)
			count_value_reg <= count_value_reg + 8'h01;
	end

	always_ff @(posedge clock)
	begin
		if (reset || stop_mode)
			capture_reg <= COUNT_RESET;
		else if (capture_hit)
			capture_reg <= count_value_reg;
	end

	// ----------------------------------------------------------------
	// Flags
	// ----------------------------------------------------------------
	// Every flag lets a hardware set win over a clear in the same cycle.
	always_ff @(posedge clock)
	begin
		if (reset || stop_mode)
			timer_irq_request_reg <= 1'b0;
		else if (overflow || capture_hit)
			timer_irq_request_reg <= 1'b1;
		else if (timer_irq_clear)
			timer_irq_request_reg <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (reset || stop_mode)
			capture_done_flag_reg <= 1'b0;
		else if (capture_hit)
			capture_done_flag_reg <= 1'b1;
		else if (clear_done)
			capture_done_flag_reg <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (reset || stop_mode)
			capture_overrun_flag_reg <= 1'b0;
		else if ((capture_hit || overflow) && capture_done_flag_reg)
			capture_overrun_flag_reg <= 1'b1;
		else if (clear_overrun)
			capture_overrun_flag_reg <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			irq_out_reg <= 1'b0;
		else
			irq_out_reg <= timer_irq_request_reg && !timer_irq_mask;
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// In capture mode both nibbles come from the frozen capture value.
	always_comb
	begin
		case (cpu_addr)
			ADDR_READ_DIRECT:
				rdata_next = capture_enable_bit ? capture_reg[7:4] :
					count_value_reg[7:4];
			ADDR_READ_LATCHED:
				rdata_next = capture_enable_bit ? capture_reg[3:0] :
					readback_nibble_latched_reg;
			ADDR_CAPTURE_FLAGS:
				rdata_next = {2'b00, capture_overrun_flag_reg, capture_done_flag_reg};
			default:
				rdata_next = 4'h0;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			readback_nibble_latched_reg <= NIBBLE_RESET;
		else if (cpu_rd && cpu_addr == ADDR_READ_DIRECT)
			readback_nibble_latched_reg <= count_value_reg[3:0];
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			cpu_rdata_reg <= 4'h0;
		else if (cpu_rd)
			cpu_rdata_reg <= rdata_next;
	end

	// ----------------------------------------------------------------
	// Shared pin routing
	// ----------------------------------------------------------------
	// The port sees the pin only while it is not handed to the timer.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			port_pin_reg <= 1'b1;
			ext_irq_reg <= 1'b1;
		end
		else
		begin
			port_pin_reg <= route_bit ? 1'b1 : pin_sync;
			ext_irq_reg <= route_bit ? pin_sync : 1'b1;
		end
	end

	assign cpu_rdata = cpu_rdata_reg;
	assign timer_irq_request = timer_irq_request_reg;
	assign timer_irq_out = irq_out_reg;
	assign capture_done_flag = capture_done_flag_reg;
	assign capture_overrun_flag = capture_overrun_flag_reg;
	assign port_pin_in = port_pin_reg;
	assign external_irq_zero = ext_irq_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	sequence s_capture;
		capture_hit && !stop_mode && !reload_wr && !capture_start;
	endsequence

	sequence s_wrap_free;
		overflow && !stop_mode && !reload_mode_bit;
	endsequence

	sequence s_wrap_reload;
		overflow && !stop_mode && reload_mode_bit && !capture_enable_bit;
	endsequence

	AST_RELOAD_LOAD: assert property (
		reload_wr && !stop_mode |=>
		count_value_reg == {$past(cpu_wdata), reload_nibble_first_reg})
		else $error("reload write did not load the counter");

	AST_CAPTURE_COPY: assert property (
		s_capture |=> capture_reg == $past(count_value_reg) &&
		count_value_reg == COUNT_RESET && timer_irq_request_reg)
		else $error("capture did not copy and clear");

	AST_DONE_SET: assert property (
		capture_hit && !stop_mode |=> capture_done_flag_reg)
		else $error("capture done flag not set");

	AST_OVERRUN_SET: assert property (
		(capture_hit || overflow) && capture_done_flag_reg && !stop_mode |=> capture_overrun_flag_reg)
		else $error("overrun flag not set");

	AST_FREE_WRAP: assert property (
		s_wrap_free |=> count_value_reg == COUNT_RESET && timer_irq_request_reg)
		else $error("free-running wrap wrong");

	AST_RELOAD_WRAP: assert property (
		s_wrap_reload |=> count_value_reg ==
		{$past(reload_nibble_second_reg), $past(reload_nibble_first_reg)})
		else $error("reload wrap wrong");

	AST_IRQ_STICKY: assert property (
		timer_irq_request_reg && !timer_irq_clear && !stop_mode |=> timer_irq_request_reg)
		else $error("request flag dropped by itself");

	AST_MODE_DELAY: assert property (
		cpu_wr && cpu_addr == ADDR_TIMER_MODE_FIRST && !stop_mode |=>
		timer_mode_first_reg == $past(timer_mode_first_reg) &&
		mode_delay_reg == MODE_FIRST_DELAY)
		else $error("first mode write took effect too soon");

	AST_CAPTURE_START: assert property (
		capture_start && !reload_wr && !stop_mode |=>
		count_value_reg == COUNT_RESET && capture_enable_bit)
		else $error("capture enable did not clear counter");

	AST_READ_LATCH: assert property (
		cpu_rd && cpu_addr == ADDR_READ_DIRECT |=>
		readback_nibble_latched_reg == $past(count_value_reg[3:0]))
		else $error("low nibble not latched on direct read");

	AST_IRQ_OUT: assert property (
		timer_irq_request_reg && !timer_irq_mask |=> irq_out_reg)
		else $error("unmasked request did not raise interrupt");

endmodule // mftc_timer
